/* File: hw/pcs_map.vh */
// latency, compensation and coding constants for the pcs datapath
// What this block does
// R1: all stage latencies counted in parallel word clock cycles
// R2: fabric bridge, same clock, no gearing: three cycles, one when bypassed
// R3: fabric bridge, different clocks, no gearing: up to five, average three, bypass one
// R4: fabric bridge with gearing: one to five cycles, typically three, never bypassed
// R5: transmit 8b10b encoder: two cycles, one when bypassed
// R6: transmit bridge to serializer: two cycles, one when bypassed
// R7: receive bridge from deserializer: fixed two cycles
// R8: word alignment: at most four cycles, about three typically
// R9: receive 8b10b decoder: fixed one cycle
// R10: clock tolerance compensation: seven to twenty-three cycles, fifteen average, bypass one
// R11: stage order rx: bridge, align, decode, compensation, fabric; tx: fabric, encode, bridge
// R12: 8b10b coding for packet standards, plus uncoded 8-bit mode
`ifndef PCS_MAP_VH
`define PCS_MAP_VH

`define PCS_FAB_LAT 3
`define PCS_ENC_LAT 2
`define PCS_TXSER_LAT 2
`define PCS_RXSER_LAT 2
`define PCS_ALIGN_LAT 3
`define PCS_DEC_LAT 1
`define PCS_COMP_MID 15
`define PCS_COMP_LOW 7
`define PCS_COMP_HIGH 23
`define PCS_COMP_AW 5
`define PCS_SKIP_CHAR 8'h1c
`define PCS_COMMA_NEG 7'h1f
`define PCS_COMMA_POS 7'h60
`define PCS_K28_6B 6'h0f
`define PCS_ALT_4B 4'h7

`endif

/* File: hw/pcs_delay_line.v */
// fixed-latency register pipeline with a one-cycle bypass path
module pcs_delay_line #(
  parameter W = 8,
  parameter DEPTH = 3
) (
  input wire clk,
  input wire rst_n,
  input wire bypass,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage_ff [0:DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_stage
      if (g == 0) begin : g_first
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            stage_ff[0] <= {W{1'b0}};
          end else begin
            stage_ff[0] <= din;
          end
        end
      end else if (g == DEPTH - 1) begin : g_last
        // last flop takes the input directly when bypassed
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            stage_ff[g] <= {W{1'b0}};
          end else begin
            stage_ff[g] <= bypass ? din : stage_ff[g-1];
          end
        end
      end else begin : g_mid
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            stage_ff[g] <= {W{1'b0}};
          end else begin
            stage_ff[g] <= stage_ff[g-1];
          end
        end
      end
    end
  endgenerate
  assign dout = stage_ff[DEPTH-1];
endmodule // pcs_delay_line

/* File: hw/pcs_clock_tolerance_compensation.v */
// elastic buffer that adds or drops skip characters to hold its fill in band
`include "pcs_map.vh"
module pcs_clock_tolerance_compensation (
  input wire clk,
  input wire rst_n,
  input wire bypass,
  input wire in_valid,
  input wire [9:0] in_word,
  output reg out_valid_ff,
  output reg [9:0] out_word_ff
);
  reg [9:0] mem [0:(1<<`PCS_COMP_AW)-1];
  reg [`PCS_COMP_AW-1:0] wr_ptr_ff;
  reg [`PCS_COMP_AW-1:0] rd_ptr_ff;
  reg primed_ff;
  wire [`PCS_COMP_AW-1:0] fill = wr_ptr_ff - rd_ptr_ff;
  wire [9:0] head = mem[rd_ptr_ff];
  wire [9:0] next_head = mem[rd_ptr_ff + 5'h01];
  wire head_skip = head[8] && (head[7:0] == `PCS_SKIP_CHAR);

  always @(posedge clk) begin
    if (in_valid && !bypass) begin
      mem[wr_ptr_ff] <= in_word;
    end
  end

  // R10 fill band control
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= 5'h00;
      rd_ptr_ff <= 5'h00;
      primed_ff <= 1'b0;
      out_valid_ff <= 1'b0;
      out_word_ff <= 10'h000;
    end else if (bypass) begin
      wr_ptr_ff <= 5'h00;
      rd_ptr_ff <= 5'h00;
      primed_ff <= 1'b0;
      out_valid_ff <= in_valid;
      out_word_ff <= in_word;
    end else begin
      if (in_valid) begin
        wr_ptr_ff <= wr_ptr_ff + 5'h01;
      end
      if (!primed_ff) begin
        out_valid_ff <= 1'b0;
        if (fill >= `PCS_COMP_MID - 1) begin
          primed_ff <= 1'b1;
        end
      end else if (fill == 5'h00) begin
        // underflow: refill to the middle before reading again
        out_valid_ff <= 1'b0;
        primed_ff <= 1'b0;
      end else if (head_skip && fill <= `PCS_COMP_LOW) begin
        // repeat the skip to lengthen the delay
        out_valid_ff <= 1'b1;
        out_word_ff <= head;
      end else if (head_skip && fill >= `PCS_COMP_HIGH - 1 && fill >= 5'h02) begin
        // drop the skip to shorten the delay
        out_valid_ff <= 1'b1;
        out_word_ff <= next_head;
        rd_ptr_ff <= rd_ptr_ff + 5'h02;
      end else begin
        out_valid_ff <= 1'b1;
        out_word_ff <= head;
        rd_ptr_ff <= rd_ptr_ff + 5'h01;
      end
    end
  end
endmodule // pcs_clock_tolerance_compensation

/* File: hw/pcs_datapath.v */
// transmit and receive coding datapath of one transceiver channel
`include "pcs_map.vh"
module pcs_datapath (
  input wire clk,
  input wire resetn,
  input wire mode_raw8,
  input wire gear_en,
  input wire fab_bypass,
  input wire tx_ser_bypass,
  input wire comp_bypass,
  input wire align_en,
  input wire [7:0] tx_data,
  input wire tx_k,
  output wire [9:0] tx_word,
  input wire [9:0] rx_word,
  input wire rx_word_valid,
  output wire [7:0] rx_data,
  output wire rx_k,
  output wire rx_valid,
  output wire rx_code_err,
  output reg rx_aligned_ff
);
  reg rst_meta_ff;
  reg rst_sync_ff;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  // coding tables, codes held as abcdei fghj with a in the msb
  function [5:0] enc6;
    input [4:0] x;
    begin
      case (x)
        5'd0: enc6 = 6'h27;
        5'd1: enc6 = 6'h1d;
        5'd2: enc6 = 6'h2d;
        5'd3: enc6 = 6'h31;
        5'd4: enc6 = 6'h35;
        5'd5: enc6 = 6'h29;
        5'd6: enc6 = 6'h19;
        5'd7: enc6 = 6'h38;
        5'd8: enc6 = 6'h39;
        5'd9: enc6 = 6'h25;
        5'd10: enc6 = 6'h15;
        5'd11: enc6 = 6'h34;
        5'd12: enc6 = 6'h0d;
        5'd13: enc6 = 6'h2c;
        5'd14: enc6 = 6'h1c;
        5'd15: enc6 = 6'h17;
        5'd16: enc6 = 6'h1b;
        5'd17: enc6 = 6'h23;
        5'd18: enc6 = 6'h13;
        5'd19: enc6 = 6'h32;
        5'd20: enc6 = 6'h0b;
        5'd21: enc6 = 6'h2a;
        5'd22: enc6 = 6'h1a;
        5'd23: enc6 = 6'h3a;
        5'd24: enc6 = 6'h33;
        5'd25: enc6 = 6'h26;
        5'd26: enc6 = 6'h16;
        5'd27: enc6 = 6'h36;
        5'd28: enc6 = 6'h0e;
        5'd29: enc6 = 6'h2e;
        5'd30: enc6 = 6'h1e;
        default: enc6 = 6'h2b;
      endcase
    end
  endfunction

  function [3:0] enc4;
    input [2:0] y;
    begin
      case (y)
        3'd0: enc4 = 4'hb;
        3'd1: enc4 = 4'h9;
        3'd2: enc4 = 4'h5;
        3'd3: enc4 = 4'hc;
        3'd4: enc4 = 4'hd;
        3'd5: enc4 = 4'ha;
        3'd6: enc4 = 4'h6;
        default: enc4 = 4'he;
      endcase
    end
  endfunction

  function [2:0] pop6;
    input [5:0] s;
    begin
      pop6 = {2'b00, s[0]} + {2'b00, s[1]} + {2'b00, s[2]} + {2'b00, s[3]} + {2'b00, s[4]} + {2'b00, s[5]};
    end
  endfunction

  function [2:0] pop4;
    input [3:0] f;
    begin
      pop4 = {2'b00, f[0]} + {2'b00, f[1]} + {2'b00, f[2]} + {2'b00, f[3]};
    end
  endfunction

  // returns {new running disparity, code}; disparity 1 is positive
  function [10:0] enc10;
    input [7:0] d;
    input k;
    input rd;
    reg [5:0] s;
    reg [3:0] f;
    reg rdm;
    reg alt;
    begin
      s = (k && d[4:0] == 5'd28) ? `PCS_K28_6B : enc6(d[4:0]);
      if (rd && (pop6(s) != 3'd3 || d[4:0] == 5'd7)) begin
        s = ~s;
      end
      rdm = rd ^ (pop6(s) != 3'd3);
      alt = (d[7:5] == 3'd7) && (k || (!rdm && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20)) ||
            (rdm && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)));
      f = alt ? `PCS_ALT_4B : enc4(d[7:5]);
      // k28 balanced nibbles also follow the disparity
      if ((rdm && (pop4(f) != 3'd2 || d[7:5] == 3'd3)) ||
          (!rdm && k && d[4:0] == 5'd28 && pop4(f) == 3'd2 && d[7:5] != 3'd3)) begin
        f = ~f;
      end
      enc10 = {rdm ^ (pop4(f) != 3'd2), s, f};
    end
  endfunction

  // returns {code error, k flag, byte}
  function [9:0] dec10;
    input [9:0] c;
    reg [5:0] s;
    reg [3:0] f;
    reg [5:0] t6;
    reg [3:0] t4;
    reg [4:0] x;
    reg [2:0] y;
    reg e6;
    reg e4;
    reg kk;
    integer i;
    begin
      s = c[9:4];
      f = (c[9:4] == ~`PCS_K28_6B) ? ~c[3:0] : c[3:0];
      x = 5'd0;
      y = 3'd0;
      e6 = 1'b1;
      e4 = 1'b1;
      kk = 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        t6 = enc6(i[4:0]);
        if (t6 == s || ((~t6) == s && (pop6(t6) != 3'd3 || i == 7))) begin
          x = i[4:0];
          e6 = 1'b0;
        end
      end
      if (s == `PCS_K28_6B || s == ~`PCS_K28_6B) begin
        x = 5'd28;
        kk = 1'b1;
        e6 = 1'b0;
      end
      for (i = 0; i < 8; i = i + 1) begin
        t4 = enc4(i[2:0]);
        if (t4 == f || ((~t4) == f && (pop4(t4) != 3'd2 || i == 3))) begin
          y = i[2:0];
          e4 = 1'b0;
        end
      end
      if (f == `PCS_ALT_4B || f == ~`PCS_ALT_4B) begin
        y = 3'd7;
        e4 = 1'b0;
        if (x == 5'd23 || x == 5'd27 || x == 5'd29 || x == 5'd30) begin
          kk = 1'b1;
        end
      end
      dec10 = {e6 | e4, kk, y, x};
    end
  endfunction

  // R1 stage figures below are word clock cycles
  // R11 transmit order: fabric bridge, encoder, serializer bridge
  wire [8:0] tx_fab_out;
  wire fab_bypass_eff;
  // R4 gearing removes the bypass path
  assign fab_bypass_eff = fab_bypass & ~gear_en;

  // R2 same-clock bridge, three or one
  // R3 single clock, so the unequal-clock case settles at its three-cycle average
  pcs_delay_line #(.W(9), .DEPTH(`PCS_FAB_LAT)) u_tx_fab (
    .clk(clk),
    .rst_n(rst_n),
    .bypass(fab_bypass_eff),
    .din({tx_k, tx_data}),
    .dout(tx_fab_out)
  );

  reg [8:0] enc_in_ff;
  reg [9:0] enc_out_ff;
  reg disp_ff;
  wire [10:0] enc_res = enc10(enc_in_ff[7:0], enc_in_ff[8], disp_ff);
  // R5 encoder two cycles, raw path one
  // R12 raw 8-bit mode leaves the byte uncoded
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_in_ff <= 9'h000;
      enc_out_ff <= 10'h000;
      disp_ff <= 1'b0;
    end else begin
      enc_in_ff <= tx_fab_out;
      if (mode_raw8) begin
        enc_out_ff <= {2'b00, tx_fab_out[7:0]};
      end else begin
        enc_out_ff <= enc_res[9:0];
        disp_ff <= enc_res[10];
      end
    end
  end

  // R6 serializer bridge two or one
  pcs_delay_line #(.W(10), .DEPTH(`PCS_TXSER_LAT)) u_tx_ser (
    .clk(clk),
    .rst_n(rst_n),
    .bypass(tx_ser_bypass),
    .din(enc_out_ff),
    .dout(tx_word)
  );

  // R11 receive order: bridge, align, decode, compensation, fabric bridge
  wire [10:0] rx_ser_out;
  // R7 deserializer bridge fixed two
  pcs_delay_line #(.W(11), .DEPTH(`PCS_RXSER_LAT)) u_rx_ser (
    .clk(clk),
    .rst_n(rst_n),
    .bypass(1'b0),
    .din({rx_word_valid, rx_word}),
    .dout(rx_ser_out)
  );

  reg [10:0] al_s1_ff;
  reg [10:0] al_s2_ff;
  reg [3:0] al_off_ff;
  reg [10:0] al_out_ff;
  wire [19:0] al_win = {al_s2_ff[9:0], al_s1_ff[9:0]};
  reg al_found;
  reg [3:0] al_found_off;
  reg [3:0] al_off_use;
  integer o;
  always @* begin
    al_found = 1'b0;
    al_found_off = 4'h0;
    for (o = 9; o >= 0; o = o - 1) begin
      if (al_win[19-o -: 7] == `PCS_COMMA_NEG || al_win[19-o -: 7] == `PCS_COMMA_POS) begin
        al_found = 1'b1;
        al_found_off = o[3:0];
      end
    end
    if (mode_raw8 || !align_en) begin
      al_off_use = 4'h0;
    end else if (al_found && al_s1_ff[10] && al_s2_ff[10]) begin
      al_off_use = al_found_off;
    end else begin
      al_off_use = al_off_ff;
    end
  end

  // R8 alignment three cycles, under the four-cycle bound
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      al_s1_ff <= 11'h000;
      al_s2_ff <= 11'h000;
      al_off_ff <= 4'h0;
      al_out_ff <= 11'h000;
      rx_aligned_ff <= 1'b0;
    end else begin
      al_s1_ff <= rx_ser_out;
      al_s2_ff <= al_s1_ff;
      al_off_ff <= al_off_use;
      al_out_ff <= {al_s2_ff[10], al_win[19-al_off_use -: 10]};
      if (mode_raw8 || !align_en) begin
        rx_aligned_ff <= 1'b0;
      end else if (al_found && al_s1_ff[10] && al_s2_ff[10]) begin
        rx_aligned_ff <= 1'b1;
      end
    end
  end

  reg [10:0] dec_out_ff;
  wire [9:0] dec_res = dec10(al_out_ff[9:0]);
  // R9 decoder one cycle
  // R12 raw mode passes the low byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_out_ff <= 11'h000;
    end else if (mode_raw8) begin
      dec_out_ff <= {al_out_ff[10], 2'b00, al_out_ff[7:0]};
    end else begin
      dec_out_ff <= {al_out_ff[10], dec_res & {10{al_out_ff[10]}}};
    end
  end

  wire comp_valid;
  wire [9:0] comp_word;
  // R10 compensation buffer, fifteen nominal, one when bypassed
  pcs_clock_tolerance_compensation u_comp (
    .clk(clk),
    .rst_n(rst_n),
    .bypass(comp_bypass),
    .in_valid(dec_out_ff[10]),
    .in_word(dec_out_ff[9:0]),
    .out_valid_ff(comp_valid),
    .out_word_ff(comp_word)
  );

  wire [10:0] rx_fab_out;
  // R2 receive fabric bridge, three or one
  // R4 bypass ignored under gearing
  pcs_delay_line #(.W(11), .DEPTH(`PCS_FAB_LAT)) u_rx_fab (
    .clk(clk),
    .rst_n(rst_n),
    .bypass(fab_bypass_eff),
    .din({comp_valid, comp_word}),
    .dout(rx_fab_out)
  );

  assign rx_valid = rx_fab_out[10];
  assign rx_code_err = rx_fab_out[9];
  assign rx_k = rx_fab_out[8];
  assign rx_data = rx_fab_out[7:0];
endmodule // pcs_datapath

/* File: dv/pcs_datapath_properties.sv */
// port-level assertions for the pcs coding datapath
module pcs_datapath_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_raw8,
  input wire logic gear_en,
  input wire logic fab_bypass,
  input wire logic tx_ser_bypass,
  input wire logic comp_bypass,
  input wire logic align_en,
  input wire logic [7:0] tx_data,
  input wire logic tx_k,
  input wire logic [9:0] tx_word,
  input wire logic [9:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_k,
  input wire logic rx_valid,
  input wire logic rx_code_err,
  input wire logic rx_aligned_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cfg_ff;
  logic [4:0] age_ff;
  wire [5:0] cfg = {mode_raw8, gear_en, fab_bypass, tx_ser_bypass, comp_bypass, align_en};
  // a mode edge is seen one cycle before the age counter restarts
  wire calm = age_ff > 5'h0b && cfg == cfg_ff;
  wire raw = mode_raw8 && calm;
  wire cod = !mode_raw8 && comp_bypass && !gear_en && calm && rx_word_valid;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // cycles since the mode inputs last moved
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= 6'h00;
      age_ff <= 5'h00;
    end else begin
      cfg_ff <= cfg;
      age_ff <= (cfg != cfg_ff) ? 5'h00 : ((age_ff == 5'h1f) ? age_ff : age_ff + 5'h01);
    end
  end
  property p_tx_min;
    raw && !gear_en && fab_bypass && tx_ser_bypass |-> tx_word == {2'h0, $past(tx_data, 3)};
  endproperty
  a_tx_min: assert property (p_tx_min) else $error("tx lag in full bypass");
  property p_tx_ser;
    raw && !gear_en && fab_bypass && !tx_ser_bypass |-> tx_word == {2'h0, $past(tx_data, 4)};
  endproperty
  a_tx_ser: assert property (p_tx_ser) else $error("tx lag with serializer bridge");
  property p_tx_nom;
    raw && !gear_en && !fab_bypass && !tx_ser_bypass |-> tx_word == {2'h0, $past(tx_data, 6)};
  endproperty
  a_tx_nom: assert property (p_tx_nom) else $error("tx lag nominal raw");
  property p_tx_gear;
    raw && gear_en && fab_bypass && tx_ser_bypass |-> tx_word == {2'h0, $past(tx_data, 5)};
  endproperty
  a_tx_gear: assert property (p_tx_gear) else $error("tx lag with gearing");
  property p_tx_k285;
    !mode_raw8 && calm && !gear_en && !fab_bypass && !tx_ser_bypass && $past(tx_k, 7) && $past(tx_k, 8)
      && $past(tx_data, 7) == 8'hbc && $past(tx_data, 8) == 8'hbc
      |-> tx_word != $past(tx_word) && (tx_word == 10'h0fa || tx_word == 10'h305);
  endproperty
  a_tx_k285: assert property (p_tx_k285) else $error("comma code or disparity wrong");
  property p_rx_walk;
    cod && fab_bypass && rx_word == 10'h0fa |-> ##8 (age_ff < 5'h08 || rx_valid && rx_k && rx_data == 8'hbc);
  endproperty
  a_rx_walk: assert property (p_rx_walk) else $error("rx comma lag");
  property p_rx_fab;
    cod && !fab_bypass && rx_word == 10'h2aa |-> ##10 (age_ff < 5'h0a || rx_valid && !rx_k && rx_data == 8'hb5);
  endproperty
  a_rx_fab: assert property (p_rx_fab) else $error("rx lag via fabric bridge");
  property p_rx_err;
    cod && fab_bypass && rx_word == 10'h3ff |-> ##8 (age_ff < 5'h08 || rx_valid && rx_code_err);
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("bad code not flagged");
  property p_align_clr;
    (mode_raw8 || !align_en) [*2] |-> !rx_aligned_ff;
  endproperty
  a_align_clr: assert property (p_align_clr) else $error("aligned flag stuck");
endmodule // pcs_datapath_properties

/* File: dv/pcs_fabric_model.sv */
// fabric-side receiver that logs each delivered word except skip characters
module pcs_fabric_model (
  input wire logic clk,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_k,
  input wire logic rx_code_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] got[$];
  // skip fill is dropped, payload kept in order
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && !(rx_k === 1'b1 && rx_data === 8'h1c)) begin
      got.push_back({rx_code_err, rx_k, rx_data});
    end
  end
endmodule // pcs_fabric_model

/* File: dv/pcs_datapath_tb.sv */
// randomised self-checking bench for the pcs datapath
module pcs_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, mode_raw8, gear_en, fab_bypass, tx_ser_bypass, comp_bypass, align_en, tx_k, rx_word_valid;
  logic [7:0] tx_data;
  logic [9:0] rx_word;
  wire [9:0] tx_word;
  wire [7:0] rx_data;
  wire rx_k, rx_valid, rx_code_err, rx_aligned_ff;
  int err_total, compares;
  logic [7:0] th[0:23];
  logic [9:0] rh[0:23];
  logic [9:0] exp_q[$];
  logic [9:0] codes[0:3] = '{10'h0fa, 10'h2aa, 10'h155, 10'h3ff};

  pcs_datapath i_dut (.clk, .resetn, .mode_raw8, .gear_en, .fab_bypass, .tx_ser_bypass, .comp_bypass, .align_en,
    .tx_data, .tx_k, .tx_word, .rx_word, .rx_word_valid, .rx_data, .rx_k, .rx_valid, .rx_code_err, .rx_aligned_ff);
  pcs_fabric_model i_fab (.clk, .rx_valid, .rx_data, .rx_k, .rx_code_err);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // {err, k, byte}; bad codes compare on the error bit only
  function automatic logic [9:0] rx_exp(input logic [9:0] w);
    case (w)
      10'h0fa: rx_exp = 10'h1bc;
      10'h2aa: rx_exp = 10'h0b5;
      10'h155: rx_exp = 10'h04a;
      default: rx_exp = 10'h200;
    endcase
  endfunction

  function automatic logic [9:0] mask(input logic [9:0] v);
    mask = v[9] ? 10'h200 : v;
  endfunction

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    int fl, lat;
    logic [9:0] w;
    logic v;
    void'($urandom(32'he285f70e));
    {resetn, mode_raw8, gear_en, fab_bypass, tx_ser_bypass, align_en} = 6'h01;
    {comp_bypass, tx_k, rx_word_valid} = 3'h6;
    tx_data = 8'hbc;
    rx_word = 10'h000;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check({rx_valid, rx_aligned_ff, tx_word}, 12'h000, "reset");
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (24) @(posedge clk);
    repeat (4) begin
      @(negedge clk);
      w = tx_word;
      @(negedge clk);
      check((w == 10'h0fa && tx_word == 10'h305) || (w == 10'h305 && tx_word == 10'h0fa), 1'b1, "comma");
    end
    // raw configs check tx, coded configs check rx
    for (int c = 0; c < 16; c++) begin
      fl = (c[2] || !c[0]) ? 3 : 1;
      lat = c[3] ? 7 + fl : fl + 1 + (c[1] ? 1 : 2);
      for (int j = 0; j < 24; j++) begin
        th[j] = 8'($urandom);
        rh[j] = codes[2'($urandom)];
        @(posedge clk);
        {mode_raw8, gear_en, tx_ser_bypass, fab_bypass} <= {!c[3], c[2:0]};
        {tx_k, rx_word_valid, tx_data, rx_word} <= {2'h1, th[j], rh[j]};
        @(negedge clk);
        if (j > 13 && c < 8) check(tx_word, {2'h0, th[j - lat]}, "tx");
        if (j > 13 && c > 7) check({rx_valid, mask({rx_code_err, rx_k, rx_data})}, {1'b1, rx_exp(rh[j - lat])}, "rx");
      end
    end
    @(negedge clk);
    check(rx_aligned_ff, 1'b1, "aligned");
    @(posedge clk);
    {align_en, rx_word_valid} <= 2'h0;
    repeat (3) @(negedge clk);
    check(rx_aligned_ff, 1'b0, "unaligned");
    @(posedge clk);
    align_en <= 1'b1;
    repeat (40) @(posedge clk);
    // pipeline drained, so no stale word lands in the elastic store
    comp_bypass <= 1'b0;
    i_fab.got.delete();
    // gappy traffic through the elastic stage
    repeat (300) begin
      v = $urandom % 4 != 0;
      w = codes[2'($urandom)];
      @(posedge clk);
      rx_word_valid <= v;
      rx_word <= v ? w : ~rx_word;
      if (v) exp_q.push_back(rx_exp(w));
    end
    @(posedge clk);
    rx_word_valid <= 1'b0;
    repeat (60) @(posedge clk);
    check(i_fab.got.size() <= exp_q.size() && i_fab.got.size() + 14 > exp_q.size(), 1'b1, "count");
    foreach (i_fab.got[i]) check(mask(i_fab.got[i]), exp_q[i], "comp");
    complete_run();
  end

  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // pcs_datapath_tb

bind pcs_datapath pcs_datapath_properties i_props (.clk, .resetn, .mode_raw8, .gear_en, .fab_bypass, .tx_ser_bypass,
  .comp_bypass, .align_en, .tx_data, .tx_k, .tx_word, .rx_word, .rx_word_valid, .rx_data, .rx_k, .rx_valid,
  .rx_code_err, .rx_aligned_ff);
